/* File: epa_top.v */
`timescale 1ns/1ps
`include "epa_regs.vh"
// Contract
// - The step constant is signed, integer in the upper half, fraction in the lower.
// - In binary mode the fraction counts in units of 1/2^16 of a position count.
// - In decimal mode the fraction counts in units of 1/10^4 of a position count.
// - The decimal-select configuration bit picks binary or decimal fraction.
// - The index flag sets on an index event and clears only when software writes 1 to bit 0.
// - An index event copies the position count into the read-only latched register.
// - The position count is signed 32-bit, readable and writable by software.
module epa_top (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [`EPA_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [`EPA_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Encoder pins
    input wire enc_a,
    input wire enc_b,
    input wire enc_n,
    // Interrupt
    output wire irq
);
    // Write channel holding
    reg aw_full_reg;
    reg [`EPA_ADDR_W-1:0] aw_addr_reg;
    reg w_full_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    // Block registers
    reg [1:0] config_reg;
    reg [31:0] position_reg;
    reg [15:0] frac_reg;
    reg [31:0] step_const_reg;
    reg event_status_reg;
    reg [31:0] latched_pos_reg;
    reg [1:0] irq_status_reg;
    reg [1:0] irq_mask_reg;

    // Next values
    reg event_status_next;
    reg [1:0] irq_status_next;
    reg [31:0] rd_data_next;
    reg rd_hit_next;

    wire wr_go;
    wire [`EPA_IDX_W-1:0] wr_idx;
    wire [`EPA_IDX_W-1:0] rd_idx;
    wire rd_take;
    wire cfg_we;
    wire pos_we;
    wire const_we;
    wire stat_we;
    wire mask_we;
    wire step_fwd;
    wire step_rev;
    wire step_err;
    wire index_evt;
    wire [31:0] pos_step;
    wire [15:0] frac_step;
    wire [1:0] irq_events;

    function mapped;
        input [`EPA_IDX_W-1:0] idx;
        begin
            case (idx)
                `EPA_IDX_CONFIG,
                `EPA_IDX_POSITION,
                `EPA_IDX_STEP_CONST,
                `EPA_IDX_EVENT_STATUS,
                `EPA_IDX_LATCHED_POS,
                `EPA_IDX_IRQ_STATUS,
                `EPA_IDX_IRQ_MASK:
                    mapped = 1'b1;
                default:
                    mapped = 1'b0;
            endcase
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (strb[i])
                begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // Decoder and arithmetic
    epa_quad u_quad (
        .aclk(aclk),
        .aresetn(aresetn),
        .enc_a(enc_a),
        .enc_b(enc_b),
        .enc_n(enc_n),
        .index_pol(config_reg[`EPA_CFG_INDEX_POL_BIT]),
        .step_fwd(step_fwd),
        .step_rev(step_rev),
        .step_err(step_err),
        .index_evt(index_evt)
    );

    epa_scale u_scale (
        .pos_in(position_reg),
        .frac_in(frac_reg),
        .step_const(step_const_reg),
        .decimal(config_reg[`EPA_CFG_DECIMAL_BIT]),
        .step_fwd(step_fwd),
        .step_rev(step_rev),
        .pos_out(pos_step),
        .frac_out(frac_step)
    );

    // Write path: address and data in either order, one write at a time
    assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;
    assign wr_go = aw_full_reg & w_full_reg;
    assign wr_idx = aw_addr_reg[`EPA_IDX_W+1:2];
    assign cfg_we = wr_go & (wr_idx == `EPA_IDX_CONFIG);
    assign pos_we = wr_go & (wr_idx == `EPA_IDX_POSITION);
    assign const_we = wr_go & (wr_idx == `EPA_IDX_STEP_CONST);
    assign stat_we = wr_go & (wr_idx == `EPA_IDX_EVENT_STATUS);
    assign mask_we = wr_go & (wr_idx == `EPA_IDX_IRQ_MASK);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= {`EPA_ADDR_W{1'b0}};
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EPA_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(wr_idx) ? `EPA_RESP_OKAY : `EPA_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read path
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_take = s_axi_arvalid & s_axi_arready;
    assign rd_idx = s_axi_araddr[`EPA_IDX_W+1:2];

    always @*
    begin
        rd_data_next = 32'h0000_0000;
        rd_hit_next = mapped(rd_idx);
        case (rd_idx)
            `EPA_IDX_CONFIG:
                rd_data_next = {30'h0000_0000, config_reg};
            `EPA_IDX_POSITION:
                rd_data_next = position_reg;
            `EPA_IDX_STEP_CONST:
                rd_data_next = step_const_reg;
            `EPA_IDX_EVENT_STATUS:
                rd_data_next = {31'h0000_0000, event_status_reg};
            `EPA_IDX_LATCHED_POS:
                rd_data_next = latched_pos_reg;
            `EPA_IDX_IRQ_STATUS:
                rd_data_next = {30'h0000_0000, irq_status_reg};
            `EPA_IDX_IRQ_MASK:
                rd_data_next = {30'h0000_0000, irq_mask_reg};
            default:
                rd_data_next = 32'h0000_0000;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `EPA_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data_next;
            s_axi_rresp <= rd_hit_next ? `EPA_RESP_OKAY : `EPA_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Flags: a new event beats a clear in the same cycle
    assign irq_events = {step_err, index_evt};

    always @*
    begin
        event_status_next = event_status_reg;
        if (stat_we && w_strb_reg[0] && w_data_reg[`EPA_STAT_INDEX_BIT])
        begin
            event_status_next = 1'b0;
        end
        if (index_evt)
        begin
            event_status_next = 1'b1;
        end
        irq_status_next = irq_status_reg;
        if (rd_take && rd_idx == `EPA_IDX_IRQ_STATUS)
        begin
            irq_status_next = 2'h0;
        end
        irq_status_next = irq_status_next | irq_events;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            config_reg <= `EPA_RST_CONFIG;
            position_reg <= `EPA_RST_POSITION;
            frac_reg <= 16'h0000;
            step_const_reg <= `EPA_RST_STEP_CONST;
            event_status_reg <= 1'b0;
            latched_pos_reg <= `EPA_RST_LATCHED_POS;
            irq_status_reg <= 2'h0;
            irq_mask_reg <= `EPA_RST_IRQ_MASK;
        end
        else
        begin
            event_status_reg <= event_status_next;
            irq_status_reg <= irq_status_next;
            if (step_fwd || step_rev)
            begin
                position_reg <= pos_step;
                frac_reg <= frac_step;
            end
            // Remainder is meaningless across a mode change
            if (cfg_we)
            begin
                config_reg <= w_strb_reg[0] ? w_data_reg[1:0] : config_reg;
                frac_reg <= 16'h0000;
            end
            // Software write overrides a step in the same cycle
            if (pos_we)
            begin
                position_reg <= merge(position_reg, w_data_reg, w_strb_reg);
                frac_reg <= 16'h0000;
            end
            if (const_we)
            begin
                step_const_reg <= merge(step_const_reg, w_data_reg, w_strb_reg);
            end
            if (mask_we && w_strb_reg[0])
            begin
                irq_mask_reg <= w_data_reg[1:0];
            end
            if (index_evt)
            begin
                latched_pos_reg <= position_reg;
            end
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);
endmodule

/* File: epa_regs.vh */
`ifndef EPA_REGS_VH
`define EPA_REGS_VH

// Register indices, byte address is four times the index
`define EPA_ADDR_W 8
`define EPA_IDX_W 6
`define EPA_IDX_CONFIG 6'h38
`define EPA_IDX_POSITION 6'h39
`define EPA_IDX_STEP_CONST 6'h3A
`define EPA_IDX_EVENT_STATUS 6'h3B
`define EPA_IDX_LATCHED_POS 6'h3C
`define EPA_IDX_IRQ_STATUS 6'h3D
`define EPA_IDX_IRQ_MASK 6'h3E

// Reset values
`define EPA_RST_CONFIG 2'h0
`define EPA_RST_POSITION 32'h0000_0000
`define EPA_RST_STEP_CONST 32'h0001_0000
`define EPA_RST_LATCHED_POS 32'h0000_0000
`define EPA_RST_IRQ_MASK 2'h0

// Field positions
`define EPA_CFG_DECIMAL_BIT 0
`define EPA_CFG_INDEX_POL_BIT 1
`define EPA_STAT_INDEX_BIT 0
`define EPA_IRQ_INDEX_BIT 0
`define EPA_IRQ_STEP_ERR_BIT 1

// Fraction arithmetic
`define EPA_MOD_BIN 17'h1_0000
`define EPA_MOD_DEC 17'h0_2710
`define EPA_DEC_FRAC_MAX 16'h270F

// AXI responses
`define EPA_RESP_OKAY 2'h0
`define EPA_RESP_SLVERR 2'h2

`endif

/* File: epa_quad.v */
`timescale 1ns/1ps
`include "epa_regs.vh"
module epa_quad (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Encoder pins
    input wire enc_a,
    input wire enc_b,
    input wire enc_n,
    // Configuration
    input wire index_pol,
    // Decoded events
    output wire step_fwd,
    output wire step_rev,
    output wire step_err,
    output wire index_evt
);
    reg [2:0] sync1_reg;
    reg [2:0] sync2_reg;
    reg [2:0] sync3_reg;
    reg [2:0] filt_reg;
    reg [1:0] ab_prev_reg;
    reg n_prev_reg;
    wire [2:0] agree;
    wire [2:0] filt_next;
    wire [1:0] chg;
    wire n_act;
    wire n_act_prev;

    // A change counts only once stages two and three agree
    assign agree = ~(sync2_reg ^ sync3_reg);
    assign filt_next = (agree & sync2_reg) | (~agree & filt_reg);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
            filt_reg <= 3'h0;
            ab_prev_reg <= 2'h0;
            n_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= {enc_n, enc_b, enc_a};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg <= filt_next;
            ab_prev_reg <= filt_reg[1:0];
            n_prev_reg <= filt_reg[2];
        end
    end

    // Gray step: one channel moves; both moving is a lost step
    assign chg = filt_reg[1:0] ^ ab_prev_reg;
    assign step_fwd = (chg[0] ^ chg[1]) & (filt_reg[0] ^ ab_prev_reg[1]);
    assign step_rev = (chg[0] ^ chg[1]) & ~(filt_reg[0] ^ ab_prev_reg[1]);
    assign step_err = chg[0] & chg[1];

    // Index event on the edge into the active level
    assign n_act = index_pol ? filt_reg[2] : ~filt_reg[2];
    assign n_act_prev = index_pol ? n_prev_reg : ~n_prev_reg;
    assign index_evt = n_act & ~n_act_prev;
endmodule

/* File: epa_scale.v */
`timescale 1ns/1ps
`include "epa_regs.vh"
module epa_scale (
    // Current position
    input wire [31:0] pos_in,
    input wire [15:0] frac_in,
    // Scaling
    input wire [31:0] step_const,
    input wire decimal,
    // Steps
    input wire step_fwd,
    input wire step_rev,
    // Next position
    output reg [31:0] pos_out,
    output reg [15:0] frac_out
);
    wire [16:0] modulus;
    wire [15:0] cf;
    wire [31:0] ci;
    reg [16:0] sum;
    reg [16:0] dif;
    reg [16:0] tmp;

    // Fraction units are 1/2^16 or 1/10^4 of a count
    assign modulus = decimal ? `EPA_MOD_DEC : `EPA_MOD_BIN;
    // Decimal fraction above 9999 is clamped, one carry then suffices
    assign cf = (decimal && step_const[15:0] > `EPA_DEC_FRAC_MAX) ?
        `EPA_DEC_FRAC_MAX : step_const[15:0];
    // Signed integer half, unsigned fraction half
    assign ci = {{16{step_const[31]}}, step_const[31:16]};

    always @*
    begin
        sum = {1'b0, frac_in} + {1'b0, cf};
        dif = {1'b0, frac_in} - {1'b0, cf};
        tmp = 17'h0_0000;
        pos_out = pos_in;
        frac_out = frac_in;
        if (step_fwd)
        begin
            if (sum >= modulus)
            begin
                tmp = sum - modulus;
                frac_out = tmp[15:0];
                pos_out = pos_in + ci + 32'h0000_0001;
            end
            else
            begin
                frac_out = sum[15:0];
                pos_out = pos_in + ci;
            end
        end
        else if (step_rev)
        begin
            if (dif[16])
            begin
                tmp = dif + modulus;
                frac_out = tmp[15:0];
                pos_out = pos_in - ci - 32'h0000_0001;
            end
            else
            begin
                frac_out = dif[15:0];
                pos_out = pos_in - ci;
            end
        end
    end
endmodule

/* File: epa_enc_model.sv */
`timescale 1ns/1ps
module epa_enc_model (
    // Clock
    input wire aclk,
    // Commands
    input wire load,
    input wire dir,
    input wire jump,
    input wire [7:0] n,
    input wire idx,
    // Encoder pins
    output wire enc_a,
    output wire enc_b,
    output reg enc_n,
    output wire busy
);
    reg [1:0] ph = 2'h0;
    reg [7:0] left = 8'h00;
    reg [2:0] hold = 3'h0;
    // Forward order 00, 10, 11, 01
    assign enc_a = ph[0] ^ ph[1];
    assign enc_b = ph[1];
    assign busy = (left != 8'h00) || (hold != 3'h0);
    initial enc_n = 1'b0;
    // States outlast the three-cycle filter
    always @(posedge aclk)
    begin
        enc_n <= idx;
        if (load)
        begin
            left <= n;
            hold <= 3'h4;
            if (jump)
                ph <= ph + 2'h2;
        end
        else if (hold != 3'h0)
            hold <= hold - 3'h1;
        else if (left != 8'h00)
        begin
            ph <= dir ? ph - 2'h1 : ph + 2'h1;
            left <= left - 8'h01;
            hold <= 3'h4;
        end
    end
endmodule

/* File: epa_top_checker.sv */
`timescale 1ns/1ps
`include "epa_regs.vh"
module epa_top_checker (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Write bus
    input wire [`EPA_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Read bus
    input wire [`EPA_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Interrupt
    input wire irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire w_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire r_take = s_axi_arvalid && s_axi_arready;
    wire [5:0] aw_i = s_axi_awaddr[7:2];
    wire [5:0] ar_i = s_axi_araddr[7:2];
    // Map is one contiguous run of indices
    wire aw_map = (aw_i >= `EPA_IDX_CONFIG) && (aw_i <= `EPA_IDX_IRQ_MASK);
    wire ar_map = (ar_i >= `EPA_IDX_CONFIG) && (ar_i <= `EPA_IDX_IRQ_MASK);
    property p_b_ok;
        w_take && aw_map |-> ##2 s_axi_bvalid && s_axi_bresp == `EPA_RESP_OKAY;
    endproperty
    a_b_ok: assert property (p_b_ok) else $error("bad write answer");
    property p_r_ok;
        r_take && ar_map |=> s_axi_rvalid && s_axi_rresp == `EPA_RESP_OKAY;
    endproperty
    a_r_ok: assert property (p_r_ok) else $error("bad read answer");
    property p_r_err;
        r_take && !ar_map |=> s_axi_rvalid && s_axi_rresp == `EPA_RESP_SLVERR
            && s_axi_rdata == 32'h0000_0000;
    endproperty
    a_r_err: assert property (p_r_err) else $error("unmapped read");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer lost");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer lost");
    property p_b_drop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_drop: assert property (p_b_drop) else $error("write answer stuck");
    property p_w_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_busy: assert property (p_w_busy) else $error("write overlap");
    property p_ar_rdy;
        s_axi_arready != s_axi_rvalid;
    endproperty
    a_ar_rdy: assert property (p_ar_rdy) else $error("read overlap");
    // Reset must clear answers and interrupt
    property p_rst;
        disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule

/* File: tb_epa_top.sv */
`timescale 1ns/1ps
`include "epa_regs.vh"
module tb_epa_top;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [7:0] s_axi_awaddr = 8'h00;
    reg s_axi_awvalid = 1'b0;
    reg [31:0] s_axi_wdata = 32'h0000_0000;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg s_axi_wvalid = 1'b0;
    reg s_axi_bready = 1'b0;
    reg [7:0] s_axi_araddr = 8'h00;
    reg s_axi_arvalid = 1'b0;
    reg s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire enc_a, enc_b, enc_n, irq, busy;
    reg load = 1'b0;
    reg dir = 1'b0;
    reg jump = 1'b0;
    reg [7:0] n = 8'h00;
    reg idx = 1'b0;
    integer n_fail = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer i;
    reg [31:0] rd_data;
    reg [1:0] rd_resp;
    reg aw_d, w_d;
    // Row: decimal, constant, reverse, steps, position
    reg [73:0] rows [0:6];
    epa_top dut_u (.*);
    epa_enc_model enc_u (.*);
    initial forever #5 aclk = ~aclk;
    task test_done;
    begin
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail = n_fail + 1;
            $display("Error %0t timeout", $time);
            test_done;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("Error %0t got %h want %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [7:0] a, input [31:0] d);
    begin
        aw_d = 1'b0;
        w_d = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_d && w_d))
        begin
            @(posedge aclk);
            if (!aw_d && s_axi_awready)
            begin
                aw_d = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_d && s_axi_wready)
            begin
                w_d = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        @(posedge aclk);
        while (!s_axi_bvalid)
            @(posedge aclk);
        s_axi_bready <= 1'b0;
    end
    endtask
    task rd(input [7:0] a);
    begin
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (!s_axi_arready)
            @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        while (!s_axi_rvalid)
            @(posedge aclk);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    end
    endtask
    // Pipeline of the pins is five edges, eight leaves margin
    task run(input d, input j, input [7:0] k);
    begin
        @(posedge aclk);
        load <= 1'b1;
        dir <= d;
        jump <= j;
        n <= k;
        @(posedge aclk);
        load <= 1'b0;
        @(posedge aclk);
        while (busy)
            @(posedge aclk);
        repeat (8) @(posedge aclk);
    end
    endtask
    initial
    begin
        rows[0] = {1'b0, 32'h0001_0000, 1'b0, 8'h03, 32'h0000_0003};
        rows[1] = {1'b0, 32'h0000_8000, 1'b0, 8'h03, 32'h0000_0001};
        rows[2] = {1'b0, 32'h0002_0000, 1'b1, 8'h02, 32'hFFFF_FFFC};
        rows[3] = {1'b0, 32'hFFFE_8000, 1'b0, 8'h02, 32'hFFFF_FFFD};
        rows[4] = {1'b1, 32'h0000_1388, 1'b0, 8'h03, 32'h0000_0001};
        rows[5] = {1'b1, 32'h0000_0FA0, 1'b0, 8'h03, 32'h0000_0001};
        rows[6] = {1'b1, 32'hFFFE_1388, 1'b0, 8'h02, 32'hFFFF_FFFD};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'hE8);
        chk(rd_data, 32'h0001_0000);
        rd(8'hF0);
        chk(rd_data, 32'h0000_0000);
        rd(8'hE4);
        chk(rd_data, 32'h0000_0000);
        $display("reset test done");
        for (i = 0; i < 7; i = i + 1)
        begin
            wr(8'hE0, {30'h0000_0000, 1'b1, rows[i][73]});
            wr(8'hE4, 32'h0000_0000);
            wr(8'hE8, rows[i][72:41]);
            run(rows[i][40], 1'b0, rows[i][39:32]);
            rd(8'hE4);
            chk(rd_data, rows[i][31:0]);
        end
        $display("scaling test done");
        wr(8'hE4, 32'h8000_0001);
        rd(8'hE4);
        chk(rd_data, 32'h8000_0001);
        wr(8'hF8, 32'h0000_0001);
        wr(8'hEC, 32'h0000_0001);
        rd(8'hEC);
        chk(rd_data, 32'h0000_0000);
        rd(8'hF4);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        wr(8'hE4, 32'h1234_5678);
        @(posedge aclk);
        idx <= 1'b1;
        repeat (6) @(posedge aclk);
        idx <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(8'hF0);
        chk(rd_data, 32'h1234_5678);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        wr(8'hEC, 32'h0000_0000);
        rd(8'hEC);
        chk(rd_data, 32'h0000_0001);
        wr(8'hEC, 32'h0000_0001);
        rd(8'hEC);
        chk(rd_data, 32'h0000_0000);
        rd(8'hF4);
        chk(rd_data, 32'h0000_0001);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        wr(8'hF0, 32'h0000_0000);
        rd(8'hF0);
        chk(rd_data, 32'h1234_5678);
        rd(8'h00);
        chk({30'h0000_0000, rd_resp}, 32'h0000_0002);
        // A and B together must not count
        run(1'b0, 1'b1, 8'h00);
        rd(8'hF4);
        chk(rd_data, 32'h0000_0002);
        rd(8'hE4);
        chk(rd_data, 32'h1234_5678);
        // Answers must stand while the master stalls
        @(posedge aclk);
        s_axi_awaddr <= 8'hE0;
        s_axi_wdata <= 32'h0000_0002;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_araddr <= 8'hE8;
        s_axi_arvalid <= 1'b1;
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
        repeat (3) @(posedge aclk);
        s_axi_bready <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        chk({31'h0000_0000, s_axi_rvalid & s_axi_bvalid}, 32'h0000_0001);
        chk(s_axi_rdata, 32'hFFFE_1388);
        chk({30'h0000_0000, s_axi_bresp}, 32'h0000_0000);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        $display("event test done");
        test_done;
    end
endmodule
bind epa_top epa_top_checker chk_u (.*);
